/* hw/pbw_pkg.sv */
// Package for the power button and wake controller: offsets, fields, timing and types
package pbw_pkg;
    // Clock and timing
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned SHORT_PRESS_MS = 4000;
    localparam int unsigned LONG_PRESS_MS = 6000;
    localparam int unsigned DEBOUNCE_US = 10;
    localparam int unsigned USB_BLANK_MS = 1000;
    localparam longint unsigned SHORT_PRESS_CYC = longint'(CLK_HZ) * SHORT_PRESS_MS / 1000;
    localparam longint unsigned LONG_PRESS_CYC = longint'(CLK_HZ) * LONG_PRESS_MS / 1000 + 1;
    localparam longint unsigned DEBOUNCE_CYC = longint'(CLK_HZ) * DEBOUNCE_US / 1_000_000;
    localparam longint unsigned USB_BLANK_CYC = longint'(CLK_HZ) * USB_BLANK_MS / 1000;
    localparam int CNT_W = 32;

    // Register byte offsets
    localparam logic [11:0] CTRL_OFS = 12'h000;
    localparam logic [11:0] CMD_OFS = 12'h004;
    localparam logic [11:0] STAT_OFS = 12'h008;
    localparam logic [11:0] IRQ_STS_OFS = 12'h00C;
    localparam logic [11:0] IRQ_MSK_OFS = 12'h010;

    // Control fields
    localparam int CTRL_SLEEP_STANDBY_BIT = 0;
    localparam int CTRL_DEEP_STBY_BIT = 1;
    localparam int CTRL_LAST_ON_BIT = 2;
    localparam int CTRL_LED_DUAL_BIT = 3;
    localparam int CTRL_WAKE_EN_LSB = 4;
    localparam logic [31:0] CTRL_RST = 32'h0000_01F8;

    // Command codes, written by software to the command register
    localparam logic [2:0] CMD_NONE = 3'h0;
    localparam logic [2:0] CMD_S0 = 3'h1;
    localparam logic [2:0] CMD_S3 = 3'h2;
    localparam logic [2:0] CMD_S4 = 3'h3;
    localparam logic [2:0] CMD_S5 = 3'h4;

    // Event bit positions in interrupt status / mask
    localparam int EV_PWR = 0;
    localparam int EV_RTC = 1;
    localparam int EV_LAN = 2;
    localparam int EV_USB = 3;
    localparam int EV_PCIE = 4;
    localparam int EV_STATE = 5;
    localparam int EV_FAILSAFE = 6;
    localparam int EV_SHORT = 7;
    localparam int NEV = 8;
    localparam int NWAKE = 5;

    typedef enum logic [2:0] {
        PBW_S0,
        PBW_S3,
        PBW_S4,
        PBW_S5,
        PBW_G3
    } pbw_state_t;

    // Wake pins grouped together
    typedef struct packed {
        logic pcie;
        logic usb;
        logic lan;
        logic rtc;
        logic pwr;
    } pbw_wake_t;
endpackage

/* hw/pbw_ctrl.sv */
// Power button timing, wake gating, OS power-state commands and APB registers
//
// Our own choices: the address map and register access over APB.
`timescale 1ns/1ps
module pbw_ctrl
#(
    parameter longint unsigned SHORT_CYC = pbw_pkg::SHORT_PRESS_CYC,
    parameter longint unsigned LONG_CYC = pbw_pkg::LONG_PRESS_CYC,
    parameter longint unsigned DEB_CYC = pbw_pkg::DEBOUNCE_CYC,
    parameter longint unsigned USB_BLK_CYC = pbw_pkg::USB_BLANK_CYC
)
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic pwr_btn_n,
    input wire pbw_pkg::pbw_wake_t wake_in,
    input wire logic mains_ok,
    output logic main_psu_on,
    output logic led_amber,
    output logic led_on,
    output logic stby_led,
    output logic display_wake,
    output logic irq
);
    localparam int W = pbw_pkg::CNT_W;
    localparam logic [W-1:0] SHORT_N = W'(SHORT_CYC);
    localparam logic [W-1:0] LONG_N = W'(LONG_CYC);
    localparam logic [W-1:0] DEB_N = W'(DEB_CYC);
    localparam logic [W-1:0] USB_N = W'(USB_BLK_CYC);

    // Two-stage synchronisers for the switch, wake and mains pins; stage one read only by stage two
    logic [6:0] sync1_ff;
    logic [6:0] sync2_ff;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            sync1_ff <= 7'h01;
            sync2_ff <= 7'h01;
        end
        else
        begin
            sync1_ff <= {mains_ok, wake_in, pwr_btn_n};
            sync2_ff <= sync1_ff;
        end
    end
    wire logic btn_raw = ~sync2_ff[0];
    wire pbw_pkg::pbw_wake_t wk = sync2_ff[5:1];
    wire logic mains = sync2_ff[6];

    // Debounce: level must hold steady for the debounce time
    logic btn_ff;
    logic [W-1:0] deb_cnt_ff;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            btn_ff <= 1'b0;
            deb_cnt_ff <= '0;
        end
        else if (btn_raw == btn_ff)
            deb_cnt_ff <= '0;
        else if (deb_cnt_ff >= DEB_N)
        begin
            btn_ff <= btn_raw;
            deb_cnt_ff <= '0;
        end
        else
            deb_cnt_ff <= deb_cnt_ff + W'(1);
    end

    // Hold-time counter, saturating past the long threshold
    logic [W-1:0] hold_ff;
    logic long_done_ff;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            hold_ff <= '0;
        else if (!btn_ff)
            hold_ff <= '0;
        else if (hold_ff < LONG_N)
            hold_ff <= hold_ff + W'(1);
    end
    wire logic btn_release = !btn_raw && btn_ff && (deb_cnt_ff >= DEB_N);
    wire logic short_rel = btn_release && (hold_ff < SHORT_N);
    wire logic long_hit = btn_ff && (hold_ff == LONG_N - W'(1)) && !long_done_ff;

    // Registers
    logic [31:0] ctrl_ff;
    logic [pbw_pkg::NEV-1:0] sts_ff;
    logic [pbw_pkg::NEV-1:0] msk_ff;
    logic [2:0] cmd_ff;
    wire logic wr = psel && penable && pwrite;
    wire logic [pbw_pkg::NWAKE-1:0] wake_en = ctrl_ff[pbw_pkg::CTRL_WAKE_EN_LSB +: pbw_pkg::NWAKE];
    wire logic deep_stby = ctrl_ff[pbw_pkg::CTRL_DEEP_STBY_BIT];

    pbw_pkg::pbw_state_t state_ff;
    pbw_pkg::pbw_state_t nxt_state;

    // USB blanking after mains return, and lost-mains memory for LAN
    logic [W-1:0] usb_blk_ff;
    logic after_g3_ff;
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            usb_blk_ff <= '0;
            after_g3_ff <= 1'b0;
        end
        else if (state_ff == pbw_pkg::PBW_G3)
        begin
            usb_blk_ff <= USB_N;
            after_g3_ff <= 1'b1;
        end
        else
        begin
            if (usb_blk_ff != '0)
                usb_blk_ff <= usb_blk_ff - W'(1);
            if (nxt_state == pbw_pkg::PBW_S0)
                after_g3_ff <= 1'b0;
        end
    end

    // Wake qualification per source and present state
    logic [pbw_pkg::NWAKE-1:0] wake_ok;
    always_comb
    begin
        wake_ok = '0;
        if (state_ff inside {pbw_pkg::PBW_S3, pbw_pkg::PBW_S4, pbw_pkg::PBW_S5})
        begin
            wake_ok[pbw_pkg::EV_RTC] = wk.rtc;
            wake_ok[pbw_pkg::EV_PCIE] = wk.pcie;
            wake_ok[pbw_pkg::EV_LAN] = wk.lan
                && !(state_ff == pbw_pkg::PBW_S5 && after_g3_ff && deep_stby);
            wake_ok[pbw_pkg::EV_USB] = wk.usb && (usb_blk_ff == '0)
                && (state_ff == pbw_pkg::PBW_S3 || !deep_stby);
        end
        wake_ok = wake_ok & wake_en;
    end
    wire logic any_wake = |wake_ok;

    // Power-state machine; switch events beat OS commands
    always_comb
    begin
        nxt_state = state_ff;
        case (state_ff)
            pbw_pkg::PBW_G3:
                if (mains)
                    nxt_state = ctrl_ff[pbw_pkg::CTRL_LAST_ON_BIT] ? pbw_pkg::PBW_S0 : pbw_pkg::PBW_S5;
            pbw_pkg::PBW_S0:
                if (long_hit)
                    nxt_state = pbw_pkg::PBW_S5;
                else if (short_rel)
                    nxt_state = ctrl_ff[pbw_pkg::CTRL_SLEEP_STANDBY_BIT] ? pbw_pkg::PBW_S4 : pbw_pkg::PBW_S3;
                else if (cmd_ff == pbw_pkg::CMD_S3)
                    nxt_state = pbw_pkg::PBW_S3;
                else if (cmd_ff == pbw_pkg::CMD_S4)
                    nxt_state = pbw_pkg::PBW_S4;
                else if (cmd_ff == pbw_pkg::CMD_S5)
                    nxt_state = pbw_pkg::PBW_S5;
            pbw_pkg::PBW_S3, pbw_pkg::PBW_S4:
                if (long_hit)
                    nxt_state = pbw_pkg::PBW_S5;
                else if (short_rel || any_wake || cmd_ff == pbw_pkg::CMD_S0)
                    nxt_state = pbw_pkg::PBW_S0;
            pbw_pkg::PBW_S5:
                if (short_rel || any_wake || cmd_ff == pbw_pkg::CMD_S0)
                    nxt_state = pbw_pkg::PBW_S0;
            default:
                nxt_state = pbw_pkg::PBW_G3;
        endcase
        if (!mains)
            nxt_state = pbw_pkg::PBW_G3;
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            state_ff <= pbw_pkg::PBW_G3;
        else
            state_ff <= nxt_state;
    end

    // Long press acts once per press
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            long_done_ff <= 1'b0;
        else if (!btn_ff)
            long_done_ff <= 1'b0;
        else if (long_hit)
            long_done_ff <= 1'b1;
    end

    // Outputs, all registered
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            main_psu_on <= 1'b0;
            led_amber <= 1'b0;
            led_on <= 1'b0;
            stby_led <= 1'b0;
            display_wake <= 1'b0;
        end
        else
        begin
            main_psu_on <= (nxt_state == pbw_pkg::PBW_S0);
            led_on <= (nxt_state == pbw_pkg::PBW_S0);
            led_amber <= (nxt_state == pbw_pkg::PBW_S3) && ctrl_ff[pbw_pkg::CTRL_LED_DUAL_BIT];
            stby_led <= (nxt_state != pbw_pkg::PBW_G3);
            // Display wakes on any resume except an RTC, LAN or PCIe wake without USB or switch
            if (nxt_state != pbw_pkg::PBW_S0)
                display_wake <= 1'b0;
            else if (state_ff == pbw_pkg::PBW_S0)
                display_wake <= display_wake || short_rel;
            else
                display_wake <= !(any_wake && !wake_ok[pbw_pkg::EV_USB] && !short_rel);
        end
    end

    // Event sources; set wins over write-one-to-clear
    logic [pbw_pkg::NEV-1:0] ev;
    always_comb
    begin
        ev = '0;
        ev[pbw_pkg::EV_PWR] = short_rel && state_ff != pbw_pkg::PBW_S0;
        ev[pbw_pkg::EV_SHORT] = short_rel;
        ev[pbw_pkg::EV_RTC +: 4] = wake_ok[pbw_pkg::EV_RTC +: 4];
        ev[pbw_pkg::EV_STATE] = nxt_state != state_ff;
        ev[pbw_pkg::EV_FAILSAFE] = long_hit;
    end

    // Control, mask, status and one-cycle command register
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl_ff <= pbw_pkg::CTRL_RST;
            msk_ff <= '0;
            sts_ff <= '0;
            cmd_ff <= pbw_pkg::CMD_NONE;
        end
        else
        begin
            cmd_ff <= pbw_pkg::CMD_NONE;
            if (wr && paddr == pbw_pkg::CTRL_OFS)
                ctrl_ff <= pwdata & pbw_pkg::CTRL_RST | pwdata & 32'h0000_0007;
            if (wr && paddr == pbw_pkg::IRQ_MSK_OFS)
                msk_ff <= pwdata[pbw_pkg::NEV-1:0];
            if (wr && paddr == pbw_pkg::CMD_OFS)
                cmd_ff <= pwdata[2:0];
            if (wr && paddr == pbw_pkg::IRQ_STS_OFS)
                sts_ff <= (sts_ff & ~pwdata[pbw_pkg::NEV-1:0]) | ev;
            else
                sts_ff <= sts_ff | ev;
        end
    end

    // APB read path, zero-wait; unmapped addresses answer with an error
    wire logic mapped = paddr inside {pbw_pkg::CTRL_OFS, pbw_pkg::CMD_OFS, pbw_pkg::STAT_OFS,
        pbw_pkg::IRQ_STS_OFS, pbw_pkg::IRQ_MSK_OFS};
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= '0;
            pready <= 1'b0;
            pslverr <= 1'b0;
            irq <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && !mapped;
            irq <= |(sts_ff & msk_ff);
            prdata <= '0;
            if (psel && !penable && !pwrite)
                case (paddr)
                    pbw_pkg::CTRL_OFS: prdata <= ctrl_ff;
                    pbw_pkg::STAT_OFS: prdata <= {22'h0, after_g3_ff, btn_ff, 5'(wk), 3'(state_ff)};
                    pbw_pkg::IRQ_STS_OFS: prdata <= {24'h0, sts_ff};
                    pbw_pkg::IRQ_MSK_OFS: prdata <= {24'h0, msk_ff};
                    default: prdata <= '0;
                endcase
        end
    end

    // Checks
    property p_failsafe;
        @(posedge pclk) disable iff (!presetn)
        long_hit && mains && state_ff != pbw_pkg::PBW_G3 && state_ff != pbw_pkg::PBW_S5
            |=> state_ff == pbw_pkg::PBW_S5;
    endproperty
    a_failsafe: assert property (p_failsafe) else $error("long press did not force soft-off");

    property p_s3_wake;
        @(posedge pclk) disable iff (!presetn)
        state_ff == pbw_pkg::PBW_S3 && any_wake && mains && !long_hit |=> state_ff == pbw_pkg::PBW_S0;
    endproperty
    a_s3_wake: assert property (p_s3_wake) else $error("S3 wake did not resume");

    property p_s3_psu;
        @(posedge pclk) disable iff (!presetn)
        state_ff == pbw_pkg::PBW_S3 |-> !main_psu_on && !led_on;
    endproperty
    a_s3_psu: assert property (p_s3_psu) else $error("supply on in S3");

    property p_usb_blank;
        @(posedge pclk) disable iff (!presetn)
        usb_blk_ff != '0 |-> !wake_ok[pbw_pkg::EV_USB];
    endproperty
    a_usb_blank: assert property (p_usb_blank) else $error("USB wake during blanking");

    property p_short_s0;
        @(posedge pclk) disable iff (!presetn)
        state_ff == pbw_pkg::PBW_S0 && short_rel && !long_hit && mains |=> state_ff inside {pbw_pkg::PBW_S3, pbw_pkg::PBW_S4};
    endproperty
    a_short_s0: assert property (p_short_s0) else $error("short press from working did not sleep");

    property p_deep_usb;
        @(posedge pclk) disable iff (!presetn)
        deep_stby && state_ff != pbw_pkg::PBW_S3 |-> !wake_ok[pbw_pkg::EV_USB];
    endproperty
    a_deep_usb: assert property (p_deep_usb) else $error("USB wake under deep standby");

    property p_mid_press;
        @(posedge pclk) disable iff (!presetn)
        btn_ff && hold_ff >= SHORT_N && !long_hit && !any_wake && cmd_ff == pbw_pkg::CMD_NONE && mains
            && state_ff != pbw_pkg::PBW_G3 |=> $stable(state_ff);
    endproperty
    a_mid_press: assert property (p_mid_press) else $error("mid press changed state");

    // Two cycles out of mains-off, so the registered indicator has caught up
    sequence s_powered2;
        state_ff != pbw_pkg::PBW_G3 ##1 state_ff != pbw_pkg::PBW_G3;
    endsequence
    property p_stby;
        @(posedge pclk) disable iff (!presetn)
        s_powered2 |-> stby_led;
    endproperty
    a_stby: assert property (p_stby) else $error("standby indicator dark");

    property p_restore;
        @(posedge pclk) disable iff (!presetn)
        state_ff == pbw_pkg::PBW_G3 && mains |=> state_ff ==
            ($past(ctrl_ff[pbw_pkg::CTRL_LAST_ON_BIT]) ? pbw_pkg::PBW_S0 : pbw_pkg::PBW_S5);
    endproperty
    a_restore: assert property (p_restore) else $error("wrong state after mains return");
endmodule // pbw_ctrl

/* bench/pbw_far_model.sv */
// Far-side model: power switch, wake sources and mains supply
`timescale 1ns/1ps
module pbw_far_model
(
    input wire logic pclk,
    output logic pwr_btn_n,
    output pbw_pkg::pbw_wake_t wake_in,
    output logic mains_ok
);
    // Idle: switch open on its pull-up, wakes quiet, mains present
    initial
    begin
        pwr_btn_n = 1'b1;
        wake_in = '0;
        mains_ok = 1'b1;
    end

    // Switch closed for n cycles; the length picks the next state
    task automatic press(input int n);
        @(posedge pclk);
        pwr_btn_n <= 1'b0;
        repeat (n) @(posedge pclk);
        pwr_btn_n <= 1'b1;
    endtask

    // Wake line held n cycles; the LAN bit stands for a detected wake frame
    task automatic wake(input int idx, input int n);
        @(posedge pclk);
        wake_in[idx] <= 1'b1;
        repeat (n) @(posedge pclk);
        wake_in[idx] <= 1'b0;
    endtask

    // Mains level, changed on a clock edge
    task automatic mains(input logic v);
        @(posedge pclk);
        mains_ok <= v;
    endtask
endmodule // pbw_far_model

/* bench/tb_top.sv */
// Testbench: switch timing, wake gating, OS commands, mains restore, registers
`timescale 1ns/1ps
module tb_top;
    localparam int TMO = 60000;
    logic pclk;
    logic presetn;
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic pwr_btn_n;
    pbw_pkg::pbw_wake_t wake_in;
    logic mains_ok;
    logic main_psu_on;
    logic led_amber;
    logic led_on;
    logic stby_led;
    logic display_wake;
    logic irq;
    int n_mismatch = 0;
    int n_checks = 0;
    int cyc = 0;
    logic [31:0] rd;
    logic err;

    // Short counts keep the run brief; expectations use the same values
    pbw_ctrl #(.SHORT_CYC(40), .LONG_CYC(60), .DEB_CYC(2), .USB_BLK_CYC(20)) u_pbw_ctrl
    (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .pwr_btn_n(pwr_btn_n), .wake_in(wake_in), .mains_ok(mains_ok), .main_psu_on(main_psu_on),
        .led_amber(led_amber), .led_on(led_on), .stby_led(stby_led), .display_wake(display_wake),
        .irq(irq)
    );
    pbw_far_model u_pbw_far_model
    (
        .pclk(pclk), .pwr_btn_n(pwr_btn_n), .wake_in(wake_in), .mains_ok(mains_ok)
    );

    // 200 MHz clock
    initial
    begin
        pclk = 1'b0;
        forever #2.5 pclk = ~pclk;
    end

    // Hang guard
    always @(posedge pclk)
    begin
        cyc <= cyc + 1;
        if (cyc == TMO)
        begin
            n_mismatch++;
            final_report();
        end
    end

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s exp %h got %h", what, exp, got);
        end
    endtask

    // One APB transfer, entered just after a rising edge; held until pready
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // No wait limit here; only the hang guard ends a stuck transfer
        do
            @(posedge pclk);
        while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    // Poll the state field with a bound, then judge it
    task automatic wait_st(input pbw_pkg::pbw_state_t s);
        int k;
        k = 0;
        do
        begin
            apb(1'b0, pbw_pkg::STAT_OFS, 32'h0);
            k++;
        end
        while (rd[2:0] !== s && k < 100);
        chk("state", {29'h0, s}, {29'h0, rd[2:0]});
    endtask

    // Outputs as {psu, led, amber, display, standby}
    task automatic chk_o(input logic [4:0] e);
        chk("outs", {27'h0, e}, {27'h0, main_psu_on, led_on, led_amber, display_wake, stby_led});
    endtask

    task automatic cmd(input logic [2:0] c);
        apb(1'b1, pbw_pkg::CMD_OFS, {29'h0, c});
    endtask

    task automatic t_reset;
        wait_st(pbw_pkg::PBW_S5);
        chk_o(5'b00001);
        apb(1'b0, pbw_pkg::CTRL_OFS, 32'h0);
        chk("ctrl", 32'h0000_01F8, rd);
        apb(1'b0, 12'h014, 32'h0);
        chk("slverr", 32'h1, {31'h0, err});
        apb(1'b0, pbw_pkg::CMD_OFS, 32'h0);
        chk("cmd", 32'h0, rd);
    endtask

    // Short press from soft-off; the press event drives the interrupt
    task automatic t_on;
        u_pbw_far_model.press(10);
        wait_st(pbw_pkg::PBW_S0);
        chk_o(5'b11011);
        apb(1'b1, pbw_pkg::IRQ_MSK_OFS, 32'h0000_0080);
        @(posedge pclk);
        chk("irq", 32'h1, {31'h0, irq});
        apb(1'b1, pbw_pkg::IRQ_STS_OFS, 32'h0000_00FF);
        @(posedge pclk);
        chk("irq", 32'h0, {31'h0, irq});
        apb(1'b0, pbw_pkg::IRQ_STS_OFS, 32'h0);
        chk("sts", 32'h0, {31'h0, rd[7]});
    endtask

    task automatic t_sleep;
        u_pbw_far_model.press(10);
        wait_st(pbw_pkg::PBW_S3);
        chk_o(5'b00101);
        u_pbw_far_model.wake(pbw_pkg::EV_LAN, 3);
        wait_st(pbw_pkg::PBW_S0);
        chk_o(5'b11001);
    endtask

    // A press between the two limits must leave the state alone
    task automatic t_mid;
        u_pbw_far_model.press(50);
        repeat (20) @(posedge pclk);
        wait_st(pbw_pkg::PBW_S0);
    endtask

    task automatic t_long;
        u_pbw_far_model.press(80);
        repeat (20) @(posedge pclk);
        wait_st(pbw_pkg::PBW_S5);
        apb(1'b0, pbw_pkg::IRQ_STS_OFS, 32'h0);
        chk("failsafe", 32'h1, {31'h0, rd[pbw_pkg::EV_FAILSAFE]});
    endtask

    task automatic t_standby;
        apb(1'b1, pbw_pkg::CTRL_OFS, 32'h0000_01F9);
        u_pbw_far_model.press(10);
        wait_st(pbw_pkg::PBW_S0);
        u_pbw_far_model.press(10);
        wait_st(pbw_pkg::PBW_S4);
        u_pbw_far_model.wake(pbw_pkg::EV_USB, 3);
        wait_st(pbw_pkg::PBW_S0);
        chk_o(5'b11011);
    endtask

    // OS commands, deep standby gating, bus and alarm wakes
    task automatic t_cmds;
        cmd(pbw_pkg::CMD_S4);
        wait_st(pbw_pkg::PBW_S4);
        apb(1'b1, pbw_pkg::CTRL_OFS, 32'h0000_01FB);
        u_pbw_far_model.wake(pbw_pkg::EV_USB, 3);
        repeat (10) @(posedge pclk);
        wait_st(pbw_pkg::PBW_S4);
        u_pbw_far_model.wake(pbw_pkg::EV_PCIE, 3);
        wait_st(pbw_pkg::PBW_S0);
        chk_o(5'b11001);
        cmd(pbw_pkg::CMD_S5);
        wait_st(pbw_pkg::PBW_S5);
        u_pbw_far_model.wake(pbw_pkg::EV_RTC, 3);
        wait_st(pbw_pkg::PBW_S0);
        cmd(pbw_pkg::CMD_S3);
        wait_st(pbw_pkg::PBW_S3);
        u_pbw_far_model.press(10);
        wait_st(pbw_pkg::PBW_S0);
        chk_o(5'b11011);
    endtask

    // Mains loss and return; USB is blanked right after the return
    task automatic t_mains;
        apb(1'b1, pbw_pkg::CTRL_OFS, 32'h0000_01FC);
        u_pbw_far_model.mains(1'b0);
        wait_st(pbw_pkg::PBW_G3);
        chk_o(5'b00000);
        u_pbw_far_model.mains(1'b1);
        wait_st(pbw_pkg::PBW_S0);
        cmd(pbw_pkg::CMD_S3);
        u_pbw_far_model.wake(pbw_pkg::EV_USB, 3);
        repeat (5) @(posedge pclk);
        wait_st(pbw_pkg::PBW_S3);
        repeat (30) @(posedge pclk);
        u_pbw_far_model.wake(pbw_pkg::EV_USB, 3);
        wait_st(pbw_pkg::PBW_S0);
    endtask

    // Mid-run reset, OS resume command, single-colour indicator dark in S3
    task automatic t_rst2;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (3) @(posedge pclk);
        chk_o(5'b00000);
        presetn <= 1'b1;
        @(posedge pclk);
        wait_st(pbw_pkg::PBW_S5);
        chk_o(5'b00001);
        cmd(pbw_pkg::CMD_S0);
        wait_st(pbw_pkg::PBW_S0);
        chk_o(5'b11011);
        apb(1'b1, pbw_pkg::CTRL_OFS, 32'h0000_01F0);
        cmd(pbw_pkg::CMD_S3);
        wait_st(pbw_pkg::PBW_S3);
        chk_o(5'b00001);
        cmd(pbw_pkg::CMD_S0);
        wait_st(pbw_pkg::PBW_S0);
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", n_checks, n_mismatch);
        if (n_mismatch == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // Main sequence
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        t_on();
        t_sleep();
        t_mid();
        t_long();
        t_standby();
        t_cmds();
        t_mains();
        t_rst2();
        final_report();
    end
endmodule // tb_top
